// file: shared/cpu_regs_pkg.sv
// cpu_regs_pkg: shared types and constants for the working registers and operand addressing
// assumes a single 10 MHz system clock and a synchronous active-low reset
package cpu_regs_pkg;

    localparam logic [7:0]  HX_HIGH_RESET = 8'h00;
    localparam logic [7:0]  DIRECT_PAGE   = 8'h00;
    localparam logic [15:0] PC_RESET      = 16'h0000;
    localparam logic [15:0] PC_STEP       = 16'h0001;
    localparam logic        CARRY_RESET   = 1'b0;

    typedef enum logic [3:0] {
        OP_LDA  = 4'h0,
        OP_STA  = 4'h1,
        OP_LDX  = 4'h2,
        OP_STX  = 4'h3,
        OP_TAX  = 4'h4,
        OP_TXA  = 4'h5,
        OP_XUN  = 4'h6,
        OP_LDHX = 4'h7,
        OP_MOV  = 4'h8,
        OP_ADD  = 4'h9,
        OP_AND  = 4'ha,
        OP_BRA  = 4'hb,
        OP_BSET = 4'hc,
        OP_BCLR = 4'hd,
        OP_COMPARE_BRANCH_EQUAL = 4'he,
        OP_DECREMENT_BRANCH_NONZERO = 4'hf
    } op_type;

    typedef enum logic [2:0] {
        REGISTER_ONLY_MODE  = 3'h0,
        PC_OFFSET_MODE      = 3'h1,
        INLINE_OPERAND_MODE = 3'h2,
        DIRECT_MODE         = 3'h3,
        INDEXED_MODE        = 3'h4
    } mode_type;

    typedef enum logic [3:0] {
        UN_CLR = 4'h0,
        UN_INC = 4'h1,
        UN_DEC = 4'h2,
        UN_COM = 4'h3,
        UN_NEG = 4'h4,
        UN_LSL = 4'h5,
        UN_LSR = 4'h6,
        UN_ROL = 4'h7,
        UN_ROR = 4'h8
    } unary_type;

    typedef struct packed {
        op_type     op;
        mode_type   mode;
        unary_type  un;
        logic [2:0] bitn;
    } req_type;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } mem_req_type;

endpackage

// file: verilog/addr_former.sv
// addr_former: effective address for direct, indexed and pc-offset modes
// assumes arg is the byte fetched after the opcode, pc already past that byte
`timescale 1ns/1ps
module addr_former import cpu_regs_pkg::*; (
    input  wire mode_type    mode,
    input  wire logic [7:0]  arg,
    input  wire logic [15:0] hx,
    input  wire logic [15:0] pc,
    output logic [15:0]      ea
);
    always_comb begin
        unique case (mode)
            DIRECT_MODE:    ea = {DIRECT_PAGE, arg}; // RL15
            INDEXED_MODE:   ea = hx; // RL4
            PC_OFFSET_MODE: ea = pc + {{8{arg[7]}}, arg}; // RL13
            default:        ea = pc;
        endcase
    end
endmodule

// file: verilog/x_unit.sv
// x_unit: single-operand operations on the low index byte
// assumes carry_in is the core carry flag; purely combinational
`timescale 1ns/1ps
module x_unit import cpu_regs_pkg::*; (
    input  wire unary_type  un,
    input  wire logic [7:0] val,
    input  wire logic       carry_in,
    output logic [7:0]      res,
    output logic            carry_out
);
    always_comb begin
        carry_out = carry_in;
        unique case (un)
            UN_CLR: res = 8'h00;
            UN_INC: res = val + 8'h01;
            UN_DEC: res = val - 8'h01;
            UN_COM: res = ~val;
            UN_NEG: res = 8'h00 - val;
            UN_LSL: begin
                res       = {val[6:0], 1'b0};
                carry_out = val[7];
            end
            UN_LSR: begin
                res       = {1'b0, val[7:1]};
                carry_out = val[0];
            end
            UN_ROL: begin
                res       = {val[6:0], carry_in};
                carry_out = val[7];
            end
            UN_ROR: begin
                res       = {carry_in, val[7:1]};
                carry_out = val[0];
            end
            default: res = val;
        endcase
    end
endmodule

// file: verilog/cpu_regs_operand.sv
// cpu_regs_operand: accumulator, index pointer and operand address sequencing
// assumes an internal bus whose read data is valid in the cycle mem.rd is high
//
// What this block does
// [RL1] 8-bit accumulator feeds the ALU and takes its results.
// [RL2] accumulator loads from and stores to memory through addressing modes.
// [RL3] reset leaves the accumulator untouched.
// [RL4] index pointer is 16 bits, high and low byte; indexed mode uses all 16.
// [RL5] some instructions touch only the low index byte, high byte kept.
// [RL6] low index byte clears, counts, complements, negates, shifts, rotates.
// [RL7] transfers move data accumulator to low index byte and back.
// [RL8] reset zeroes the high index byte and keeps the low byte.
// [RL9] one 16-bit address reaches all memory, registers and ports.
// [RL10] moves take source by one mode, destination by a second mode.
// [RL11] test-and-branch fetches its operand, then branches by pc offset if true.
// [RL12] register-only mode takes every operand from registers, no memory read except a branch offset.
// [RL13] pc-offset mode sign-extends the byte after opcode and adds it to pc.
// [RL14] 16-bit inline operand is read high byte first, then low byte.
// [RL15] direct mode prefixes a zero high byte to the 8-bit address.
// [RL16] untaken branch skips the addition and continues after the offset.
`timescale 1ns/1ps
module cpu_regs_operand import cpu_regs_pkg::*; (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       req_valid,
    input  wire req_type    req,
    input  wire logic [7:0] mem_rdata,
    output logic            req_ready,
    output logic            done,
    output mem_req_type     mem,
    output logic [7:0]      acc,
    output logic [7:0]      idx_high,
    output logic [7:0]      idx_low,
    output logic [15:0]     pc,
    output logic            carry
);
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_ARG    = 3'b001,
        S_ARG2   = 3'b010,
        S_OPND   = 3'b011,
        S_EXEC   = 3'b100,
        S_DEST   = 3'b101,
        S_BRANCH = 3'b110
    } state_type;

    state_type   state;
    req_type     cur;
    logic [7:0]  opnd;
    logic        taken;
    logic [15:0] ea;
    logic [15:0] br_target;
    logic [7:0]  un_res;
    logic        un_carry;
    logic        accept;
    logic        is_store;
    logic        is_branch;
    logic [7:0]  store_data;
    logic [7:0]  x_minus;
    logic        acc_en;
    logic [7:0]  next_acc;
    logic        x_en;
    logic [7:0]  next_x;
    logic        h_en;
    logic [7:0]  next_h;
    logic        c_en;
    logic        next_carry;
    logic [8:0]  sum;

    assign accept     = req_valid && req_ready && state == S_IDLE;
    assign is_store   = cur.op == OP_STA || cur.op == OP_STX;
    assign is_branch  = cur.op inside {OP_BRA, OP_BSET, OP_BCLR, OP_COMPARE_BRANCH_EQUAL, OP_DECREMENT_BRANCH_NONZERO};
    assign store_data = (cur.op == OP_STX) ? idx_low : acc;
    assign x_minus    = idx_low - 8'h01;
    assign sum        = {1'b0, acc} + {1'b0, opnd};

    addr_former u_ea (
        .mode (cur.mode),
        .arg  (mem_rdata),
        .hx   ({idx_high, idx_low}),
        .pc   (pc),
        .ea   (ea)
    );

    addr_former u_br (
        .mode (PC_OFFSET_MODE),
        .arg  (mem_rdata),
        .hx   ({idx_high, idx_low}),
        .pc   (pc),
        .ea   (br_target)
    );

    x_unit u_x (
        .un        (cur.un),
        .val       (idx_low),
        .carry_in  (carry),
        .res       (un_res),
        .carry_out (un_carry)
    );

    // register write strobes, only ever from the execute step or the second inline byte
    always_comb begin
        acc_en     = 1'b0;
        next_acc   = acc;
        x_en       = 1'b0;
        next_x     = idx_low;
        h_en       = 1'b0;
        next_h     = idx_high;
        c_en       = 1'b0;
        next_carry = carry;
        if (state == S_EXEC) begin
            unique case (cur.op)
                OP_LDA: begin
                    acc_en   = 1'b1; // RL2
                    next_acc = opnd;
                end
                OP_ADD: begin
                    acc_en     = 1'b1; // RL1
                    next_acc   = sum[7:0];
                    c_en       = 1'b1;
                    next_carry = sum[8];
                end
                OP_AND: begin
                    acc_en   = 1'b1; // RL1
                    next_acc = acc & opnd;
                end
                OP_LDX: begin
                    x_en   = 1'b1; // RL5
                    next_x = opnd;
                end
                OP_TAX: begin
                    x_en   = 1'b1; // RL7
                    next_x = acc;
                end
                OP_TXA: begin
                    acc_en   = 1'b1; // RL7
                    next_acc = idx_low;
                end
                OP_XUN: begin
                    x_en       = 1'b1; // RL6
                    next_x     = un_res;
                    c_en       = 1'b1;
                    next_carry = un_carry;
                end
                OP_DECREMENT_BRANCH_NONZERO: begin
                    x_en   = 1'b1; // RL5
                    next_x = x_minus;
                end
                OP_STA, OP_STX, OP_LDHX, OP_MOV, OP_BRA, OP_BSET, OP_BCLR, OP_COMPARE_BRANCH_EQUAL: begin
                end
            endcase
        end else if (state == S_ARG2) begin
            h_en   = 1'b1; // RL14
            next_h = opnd;
            x_en   = 1'b1;
            next_x = mem_rdata;
        end
    end

    // no reset branch: the accumulator keeps its value through reset
    always_ff @(posedge clk_sys) begin
        if (acc_en) begin
            acc <= next_acc; // RL3
        end
    end

    always_ff @(posedge clk_sys) begin
        if (x_en) begin
            idx_low <= next_x; // RL8
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            idx_high <= HX_HIGH_RESET; // RL8
        end else if (h_en) begin
            idx_high <= next_h; // RL5
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            carry <= CARRY_RESET;
        end else if (c_en) begin
            carry <= next_carry;
        end
    end

    // sequencer: one bus access per cycle, all addresses 16 bits wide
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state     <= S_IDLE;
            cur       <= '0;
            opnd      <= 8'h00;
            taken     <= 1'b0;
            pc        <= PC_RESET;
            mem       <= '0;
            done      <= 1'b0;
            req_ready <= 1'b1;
        end else begin
            mem.rd <= 1'b0;
            mem.wr <= 1'b0;
            done   <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    if (accept) begin
                        cur       <= req;
                        req_ready <= 1'b0;
                        unique case (req.mode)
                            REGISTER_ONLY_MODE, PC_OFFSET_MODE: state <= S_EXEC; // RL12
                            INDEXED_MODE: begin
                                mem.addr <= {idx_high, idx_low}; // RL4
                                if (req.op == OP_STA || req.op == OP_STX) begin
                                    mem.wr    <= 1'b1;
                                    mem.wdata <= (req.op == OP_STX) ? idx_low : acc;
                                    done      <= 1'b1;
                                    req_ready <= 1'b1;
                                    state     <= S_IDLE;
                                end else begin
                                    mem.rd <= 1'b1;
                                    state  <= S_OPND;
                                end
                            end
                            INLINE_OPERAND_MODE, DIRECT_MODE: begin
                                mem.addr <= pc;
                                mem.rd   <= 1'b1;
                                pc       <= pc + PC_STEP;
                                state    <= S_ARG;
                            end
                            default: state <= S_IDLE;
                        endcase
                    end
                end
                S_ARG: begin
                    if (cur.mode == INLINE_OPERAND_MODE) begin
                        opnd <= mem_rdata;
                        if (cur.op == OP_LDHX) begin
                            mem.addr <= pc; // RL14
                            mem.rd   <= 1'b1;
                            pc       <= pc + PC_STEP;
                            state    <= S_ARG2;
                        end else begin
                            state <= S_EXEC;
                        end
                    end else begin
                        mem.addr <= ea; // RL15
                        if (is_store) begin
                            mem.wr    <= 1'b1; // RL2
                            mem.wdata <= store_data;
                            done      <= 1'b1;
                            req_ready <= 1'b1;
                            state     <= S_IDLE;
                        end else begin
                            mem.rd <= 1'b1; // RL9
                            state  <= S_OPND;
                        end
                    end
                end
                S_ARG2: begin
                    done      <= 1'b1;
                    req_ready <= 1'b1;
                    state     <= S_IDLE;
                end
                S_OPND: begin
                    opnd  <= mem_rdata;
                    state <= S_EXEC;
                end
                S_EXEC: begin
                    if (cur.op == OP_MOV || is_branch) begin
                        mem.addr <= pc;
                        mem.rd   <= 1'b1;
                        pc       <= pc + PC_STEP;
                        state    <= (cur.op == OP_MOV) ? S_DEST : S_BRANCH; // RL10
                        unique case (cur.op)
                            OP_BSET: taken <= opnd[cur.bitn]; // RL11
                            OP_BCLR: taken <= ~opnd[cur.bitn]; // RL11
                            OP_COMPARE_BRANCH_EQUAL: taken <= acc == opnd; // RL11
                            OP_DECREMENT_BRANCH_NONZERO: taken <= x_minus != 8'h00; // RL11
                            default: taken <= 1'b1;
                        endcase
                    end else begin
                        done      <= 1'b1;
                        req_ready <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
                S_DEST: begin
                    mem.addr  <= {DIRECT_PAGE, mem_rdata}; // RL10
                    mem.wr    <= 1'b1;
                    mem.wdata <= opnd;
                    done      <= 1'b1;
                    req_ready <= 1'b1;
                    state     <= S_IDLE;
                end
                S_BRANCH: begin
                    // pc already points past the offset byte, so untaken needs no update
                    if (taken) begin
                        pc <= br_target; // RL13
                    end
                    done      <= 1'b1; // RL16
                    req_ready <= 1'b1;
                    state     <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    property p_h_reset;
        @(posedge clk_sys) !rst_n |=> idx_high == HX_HIGH_RESET;
    endproperty
    a_h_reset: assert property (p_h_reset) else $error("high index byte not zero after reset"); // RL8

    property p_direct;
        @(posedge clk_sys) disable iff (!rst_n)
        state == S_ARG && cur.mode == DIRECT_MODE
            |=> (mem.rd || mem.wr) && mem.addr == {DIRECT_PAGE, $past(mem_rdata)};
    endproperty
    a_direct: assert property (p_direct) else $error("direct address not in page zero"); // RL15

    property p_indexed;
        @(posedge clk_sys) disable iff (!rst_n)
        accept && req.mode == INDEXED_MODE |=> mem.addr == {$past(idx_high), $past(idx_low)};
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed access not at full pointer"); // RL4

    property p_rel_taken;
        @(posedge clk_sys) disable iff (!rst_n)
        state == S_BRANCH && taken
            |=> pc == $past(pc) + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)} && done;
    endproperty
    a_rel_taken: assert property (p_rel_taken) else $error("taken branch target wrong"); // RL13

    property p_rel_not;
        @(posedge clk_sys) disable iff (!rst_n)
        state == S_BRANCH && !taken |=> pc == $past(pc) && done;
    endproperty
    a_rel_not: assert property (p_rel_not) else $error("untaken branch moved pc"); // RL16

    property p_imm16;
        @(posedge clk_sys) disable iff (!rst_n)
        state == S_ARG2 |-> mem.addr == $past(mem.addr) + PC_STEP
            ##1 idx_high == $past(opnd) && idx_low == $past(mem_rdata);
    endproperty
    a_imm16: assert property (p_imm16) else $error("16-bit inline operand order wrong"); // RL14

    property p_inherent;
        @(posedge clk_sys) disable iff (!rst_n)
        accept && req.mode == REGISTER_ONLY_MODE && req.op != OP_DECREMENT_BRANCH_NONZERO
            |=> !mem.rd ##1 !mem.rd && done;
    endproperty
    a_inherent: assert property (p_inherent) else $error("register-only op touched memory"); // RL12

    property p_tax;
        @(posedge clk_sys) disable iff (!rst_n)
        state == S_EXEC && cur.op == OP_TAX |=> idx_low == $past(acc) && idx_high == $past(idx_high);
    endproperty
    a_tax: assert property (p_tax) else $error("transfer to low index byte wrong"); // RL7

    property p_mov;
        @(posedge clk_sys) disable iff (!rst_n)
        state == S_DEST |=> mem.wr && mem.wdata == $past(opnd) && mem.addr == {DIRECT_PAGE, $past(mem_rdata)};
    endproperty
    a_mov: assert property (p_mov) else $error("move destination write wrong"); // RL10

    property p_branch_fetch;
        @(posedge clk_sys) disable iff (!rst_n)
        state == S_EXEC && is_branch |=> mem.rd && mem.addr == $past(pc) ##1 done;
    endproperty
    a_branch_fetch: assert property (p_branch_fetch) else $error("branch offset not fetched"); // RL11

    c_taken: cover property (@(posedge clk_sys) disable iff (!rst_n) state == S_BRANCH && taken);
    c_not_taken: cover property (@(posedge clk_sys) disable iff (!rst_n) state == S_BRANCH && !taken);
    c_ldhx: cover property (@(posedge clk_sys) disable iff (!rst_n) state == S_ARG2);
    c_mov: cover property (@(posedge clk_sys) disable iff (!rst_n) state == S_DEST);
endmodule

// file: testbench/mem_model.sv
// mem_model: unified memory and register space on the internal bus
// assumes reads are combinational while mem.rd is high, writes land on the clock edge
`timescale 1ns/1ps
module mem_model import cpu_regs_pkg::*; (
    input  wire logic        clk_sys,
    input  wire mem_req_type mem,
    output logic [7:0]       mem_rdata
);
    logic [7:0] store [0:65535];
    logic [7:0] last;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            store[i] = 8'h00;
        end
        last = 8'h00;
    end

    // plain always: the bench preloads this array by hierarchical write, so it has more than one writer
    always @(posedge clk_sys) begin
        if (mem.wr) begin
            store[mem.addr] <= mem.wdata;
        end
    end

    always @(posedge clk_sys) begin
        if (mem.rd) begin
            last <= store[mem.addr];
        end
    end

    // bus released: inverse of last value, so a late sample cannot pass by luck
    assign mem_rdata = mem.rd ? store[mem.addr] : ~last;
endmodule

// file: testbench/tb_cpu_regs_operand.sv
// tb_cpu_regs_operand: self-checking bench for registers and operand addressing
// assumes mem_model as the far side; expected pc tracked here and checked against the pc output
`timescale 1ns/1ps
module tb_cpu_regs_operand;
    import cpu_regs_pkg::*;

    logic        clk_sys;
    logic        rst_n;
    logic        req_valid;
    req_type     req;
    logic [7:0]  mem_rdata;
    logic        req_ready;
    logic        done;
    mem_req_type mem;
    logic [7:0]  acc;
    logic [7:0]  idx_high;
    logic [7:0]  idx_low;
    logic [15:0] pc;
    logic        carry;
    int          mismatches;
    int          check_count;
    int          nrd;
    int          nwr;
    logic [15:0] ra [0:3];
    logic [15:0] wa;
    logic [7:0]  wd;
    logic [15:0] epc;

    cpu_regs_operand u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .mem_rdata(mem_rdata), .req_ready(req_ready), .done(done), .mem(mem),
        .acc(acc), .idx_high(idx_high), .idx_low(idx_low), .pc(pc), .carry(carry)
    );

    mem_model u_mem (.clk_sys(clk_sys), .mem(mem), .mem_rdata(mem_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic put(input logic [15:0] a, input logic [7:0] v);
        u_mem.store[a] = v;
    endtask

    // one instruction: present, release after accept, log bus until done
    task automatic run(input op_type op, input mode_type md, input unary_type u, input logic [2:0] b);
        nrd = 0;
        nwr = 0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{op: op, mode: md, un: u, bitn: b};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        for (int n = 0; n < 20; n++) begin
            @(negedge clk_sys);
            if (mem.rd && nrd < 4) ra[nrd] = mem.addr;
            if (mem.rd) nrd++;
            if (mem.wr) begin
                nwr++;
                wa = mem.addr;
                wd = mem.wdata;
            end
            if (done === 1'b1) break;
        end
        chk8({7'h00, done}, 8'h01, "done");
        chk8({7'h00, req_ready}, 8'h01, "ready with done");
    endtask

    task automatic brn(input op_type op, input mode_type md, input logic [2:0] b, input int nb,
                       input logic take, input logic [7:0] off);
        run(op, md, UN_CLR, b);
        epc = epc + 16'(nb) + (take ? {{8{off[7]}}, off} : 16'h0000);
        chk16(pc, epc, "branch pc");
    endtask

    task automatic t_reset;
        chk8(idx_high, HX_HIGH_RESET, "high after reset");
        chk16(pc, PC_RESET, "pc after reset");
        chk8({7'h00, carry}, 8'h00, "carry after reset");
    endtask

    task automatic t_direct;
        put(epc, 8'hff);
        put(16'h00ff, 8'h5a);
        run(OP_LDA, DIRECT_MODE, UN_CLR, 3'h0);
        chk16(ra[0], epc, "arg fetch");
        chk16(ra[1], 16'h00ff, "direct page addr");
        chk8(acc, 8'h5a, "acc load");
        epc = epc + 16'h0001;
        chk16(pc, epc, "pc after direct");
    endtask

    task automatic t_inline;
        put(epc, 8'h12);
        put(epc + 16'h0001, 8'h34);
        run(OP_LDHX, INLINE_OPERAND_MODE, UN_CLR, 3'h0);
        chk16(ra[1], epc + 16'h0001, "second inline byte");
        chk8(idx_high, 8'h12, "high first");
        chk8(idx_low, 8'h34, "low second");
        epc = epc + 16'h0002;
    endtask

    task automatic t_indexed;
        run(OP_STA, INDEXED_MODE, UN_CLR, 3'h0);
        chk16(wa, 16'h1234, "indexed addr");
        chk8(wd, 8'h5a, "store data");
        @(negedge clk_sys);
        chk8(u_mem.store[16'h1234], 8'h5a, "memory written");
    endtask

    task automatic t_transfer;
        put(epc, 8'h80);
        run(OP_LDX, INLINE_OPERAND_MODE, UN_CLR, 3'h0);
        epc = epc + 16'h0001;
        chk8(idx_high, 8'h12, "high kept by low load");
        run(OP_TXA, REGISTER_ONLY_MODE, UN_CLR, 3'h0);
        chk8(acc, 8'h80, "low to acc");
        chk8(8'(nrd), 8'h00, "no operand read");
        put(epc, 8'h3c);
        run(OP_LDA, INLINE_OPERAND_MODE, UN_CLR, 3'h0);
        epc = epc + 16'h0001;
        run(OP_TAX, REGISTER_ONLY_MODE, UN_CLR, 3'h0);
        chk8(idx_low, 8'h3c, "acc to low");
        chk8(idx_high, 8'h12, "high kept by transfer");
    endtask

    task automatic t_unary;
        unary_type  u;
        logic [7:0] x;
        logic [7:0] e;
        logic [7:0] m;
        x = 8'h96;
        for (int i = 0; i < 9; i++) begin
            u = unary_type'(i);
            m = 8'hff;
            put(epc, x);
            run(OP_LDX, INLINE_OPERAND_MODE, UN_CLR, 3'h0);
            epc = epc + 16'h0001;
            run(OP_XUN, REGISTER_ONLY_MODE, u, 3'h0);
            case (u)
                UN_CLR: e = 8'h00;
                UN_INC: e = x + 8'h01;
                UN_DEC: e = x - 8'h01;
                UN_COM: e = ~x;
                UN_NEG: e = 8'h00 - x;
                UN_LSL: e = {x[6:0], 1'b0};
                UN_LSR: e = {1'b0, x[7:1]};
                // carry in is known: left by the previous shift of this loop
                UN_ROL: e = {x[6:0], x[0]};
                default: e = {x[7], x[7:1]};
            endcase
            chk8(idx_low & m, e & m, "unary result");
            chk8(idx_high, 8'h12, "high kept by unary");
            if (u >= UN_LSL)
                chk8({7'h00, carry}, {7'h00, (u == UN_LSL || u == UN_ROL) ? x[7] : x[0]}, "shift carry");
        end
    endtask

    task automatic t_add;
        put(epc, 8'hff);
        run(OP_LDA, INLINE_OPERAND_MODE, UN_CLR, 3'h0);
        put(epc + 16'h0001, 8'h02);
        run(OP_ADD, INLINE_OPERAND_MODE, UN_CLR, 3'h0);
        epc = epc + 16'h0002;
        chk8(acc, 8'h01, "alu result into acc");
        chk8({7'h00, carry}, 8'h01, "add carry");
    endtask

    task automatic t_branch;
        put(epc, 8'hfc);
        brn(OP_BRA, PC_OFFSET_MODE, 3'h0, 1, 1'b1, 8'hfc);
        put(epc, 8'h50);
        put(16'h0050, 8'h08);
        put(epc + 16'h0001, 8'h10);
        brn(OP_BSET, DIRECT_MODE, 3'h3, 2, 1'b1, 8'h10);
        put(epc, 8'h50);
        put(epc + 16'h0001, 8'h10);
        brn(OP_BCLR, DIRECT_MODE, 3'h3, 2, 1'b0, 8'h10);
        put(epc, 8'h01);
        put(epc + 16'h0001, 8'h08);
        brn(OP_COMPARE_BRANCH_EQUAL, INLINE_OPERAND_MODE, 3'h0, 2, 1'b1, 8'h08);
        put(epc, 8'h01);
        run(OP_LDX, INLINE_OPERAND_MODE, UN_CLR, 3'h0);
        epc = epc + 16'h0001;
        put(epc, 8'h20);
        brn(OP_DECREMENT_BRANCH_NONZERO, REGISTER_ONLY_MODE, 3'h0, 1, 1'b0, 8'h20);
        chk8(idx_low, 8'h00, "count down");
        put(epc, 8'h20);
        brn(OP_DECREMENT_BRANCH_NONZERO, REGISTER_ONLY_MODE, 3'h0, 1, 1'b1, 8'h20);
    endtask

    task automatic t_move;
        put(epc, 8'h60);
        put(16'h0060, 8'ha5);
        put(epc + 16'h0001, 8'h70);
        run(OP_MOV, DIRECT_MODE, UN_CLR, 3'h0);
        epc = epc + 16'h0002;
        chk16(ra[1], 16'h0060, "move source");
        chk16(wa, 16'h0070, "move destination");
        chk8(wd, 8'ha5, "move data");
        chk16(pc, epc, "pc after move");
    endtask

    // acc and low byte must survive a reset in mid-run
    task automatic t_midreset;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        chk8(idx_high, 8'h00, "high cleared");
        chk8(idx_low, 8'hff, "low kept");
        chk8(acc, 8'h01, "acc kept");
        epc = PC_RESET;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        summarize();
    end

    initial begin
        mismatches = 0;
        check_count = 0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        epc = PC_RESET;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_direct();
        t_inline();
        t_indexed();
        t_transfer();
        t_unary();
        t_add();
        t_branch();
        t_midreset();
        t_move();
        summarize();
    end
endmodule
